// ===== dli_pkg.sv
// What this block does
// RULE_01: with rate adapter off, outside source drives reference_clock_a at the DS3 rate.
// RULE_02: adapter off: clocks b/c are inputs; on: output clock or driven low.
// RULE_03: analog transmit outputs only in bipolar modes with line_interface_unit on.
// RULE_04: digital transmit rails and line clock only in bipolar modes, pins enabled. The line clock also runs in unipolar mode here.
// RULE_05: rails change after reference clock rising edge, falling edge when inverted.
// RULE_06: rails normally timed against tx_line_clock; other clocks may be used.
// RULE_07: transmit rails invertible; analog transmit outputs never inverted.
// RULE_08: receive rails used only bipolar with interface off; analog when on.
// RULE_09: receive rails sampled on rx_line_clock edge chosen by inversion; rails invertible.
// RULE_10: receive_serial_out carries decoded receive data, delayed.
// RULE_11: tx_unipolar_data driven only in unipolar mode with pins enabled.
// RULE_12: unipolar data changes after selected clock edge; data invertible.
// RULE_13: unipolar data and code violation inputs used only in unipolar mode.
// RULE_14: unipolar mode passes every received bit to receive_serial_out when enabled.
// RULE_15: violation counter counts each rx_line_clock cycle with violation input high.
// RULE_16: unipolar inputs sampled on selected rx_line_clock edge; both invertible.
// RULE_17: bipolar marks are single-rail pulses, alternating; spaces leave rails low.
package dli_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_INV  = 8'h04;
   localparam logic [7:0] ADDR_CLOCK_RATE_ADAPTER = 8'h08;
   localparam logic [7:0] ADDR_BPV  = 8'h0C;
   localparam int CTRL_W   = 5;
   localparam int INV_W    = 9;
   localparam int CLOCK_RATE_ADAPTER_W   = 3;
   localparam int CTRL_LM  = 0;
   localparam int CTRL_ANA = 2;
   localparam int CTRL_TXE = 3;
   localparam int CTRL_RSE = 4;
   localparam int INV_TCLK = 0;
   localparam int INV_TPOS = 1;
   localparam int INV_TNEG = 2;
   localparam int INV_TDAT = 3;
   localparam int INV_RCLK = 4;
   localparam int INV_RPOS = 5;
   localparam int INV_RNEG = 6;
   localparam int INV_RDAT = 7;
   localparam int INV_RLCV = 8;
   localparam int CLOCK_RATE_ADAPTER_EN  = 0;
   localparam int CLOCK_RATE_ADAPTER_BS  = 1;
   localparam int CLOCK_RATE_ADAPTER_CS  = 2;
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [8:0] INV_RST  = 9'h000;
   localparam logic [2:0] CLOCK_RATE_ADAPTER_RST = 3'h0;
   // ----------------------------------------
   // line modes, symbols, timing
   // ----------------------------------------
   localparam logic [1:0] LM_B3ZS = 2'h0;
   localparam logic [1:0] LM_HDB3 = 2'h1;
   localparam logic [1:0] LM_AMI  = 2'h2;
   localparam logic [1:0] LM_UNIP = 2'h3;
   localparam logic [1:0] SYM_SP  = 2'h0;
   localparam logic [1:0] SYM_POS = 2'h1;
   localparam logic [1:0] SYM_NEG = 2'h2;
   localparam logic [2:0] ZRUN_B3ZS = 3'h3;
   localparam logic [2:0] ZRUN_HDB3 = 3'h4;
   localparam logic [7:0] TX_HALF_CYC   = 8'h02;
   localparam logic [7:0] CLOCK_RATE_ADAPTER_HALF_CYC = 8'h02;
   localparam int RCFG_W    = 8;
   localparam int RCFG_LM   = 0;
   localparam int RCFG_ANA  = 2;
   localparam int RCFG_RSE  = 3;
   localparam int RCFG_PINV = 4;
   localparam int RCFG_NINV = 5;
   localparam int RCFG_DINV = 6;
   localparam int RCFG_LINV = 7;
   localparam int BPV_W     = 16;
endpackage

// ===== dli_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dli_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dli_sync_st_t;
   dli_sync_st_t st_d;
   dli_sync_st_t st_q;
   always_comb begin
      st_d.s1 = d_in;
      st_d.s2 = st_q.s1;
   end
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign q_out = st_q.s2;
endmodule
`default_nettype wire

// ===== dli_rx_path.sv
`timescale 1ns/1ps
`default_nettype none
module dli_rx_path (
   input  wire logic                       rx_clk_in,
   input  wire logic                       rstn_in,
   input  wire logic [dli_pkg::RCFG_W-1:0] cfg_in,
   input  wire logic                       pos_in,
   input  wire logic                       neg_in,
   input  wire logic                       apos_in,
   input  wire logic                       aneg_in,
   input  wire logic                       dat_in,
   input  wire logic                       lcv_in,
   output logic                            rser_out,
   output logic      [dli_pkg::BPV_W-1:0]  cnt_gray_out
);
   typedef struct packed {
      logic [3:0]                sr;
      logic                      last_pos;
      logic                      seen;
      logic                      rser;
      logic [dli_pkg::BPV_W-1:0] cnt;
      logic [dli_pkg::BPV_W-1:0] gray;
   } dli_rx_st_t;
   dli_rx_st_t st_d;
   dli_rx_st_t st_q;
   logic [1:0] mode;
   logic       unip;
   logic       p;
   logic       n;
   logic       d;
   logic       v;
   logic       mark;
   logic       viol;
   assign mode = cfg_in[dli_pkg::RCFG_LM +: 2];
   assign unip = (mode == dli_pkg::LM_UNIP);
   // rails from pins only with interface off, analog otherwise [RULE_08] [RULE_09]
   assign p = (cfg_in[dli_pkg::RCFG_ANA] ? apos_in : pos_in) ^ cfg_in[dli_pkg::RCFG_PINV];
   assign n = (cfg_in[dli_pkg::RCFG_ANA] ? aneg_in : neg_in) ^ cfg_in[dli_pkg::RCFG_NINV];
   // unipolar inputs read only in unipolar mode [RULE_13] [RULE_16]
   assign d = unip & (dat_in ^ cfg_in[dli_pkg::RCFG_DINV]);
   assign v = unip & (lcv_in ^ cfg_in[dli_pkg::RCFG_LINV]);
   assign mark = p | n;
   assign viol = mark & st_q.seen & (p == st_q.last_pos);
   always_comb begin
      st_d = st_q;
      if (unip) begin
         st_d.sr = {st_q.sr[2:0], d}; // [RULE_14]
         if (v) begin
            st_d.cnt = st_q.cnt + 16'h0001; // [RULE_15]
         end
      end else begin
         st_d.sr = {st_q.sr[2:0], mark};
         if (mark) begin
            st_d.last_pos = p;
            st_d.seen     = 1'b1;
         end
         // strip zero substitution codes; plain AMI keeps the mark
         if (viol && mode == dli_pkg::LM_B3ZS) begin
            st_d.sr[2:0] = 3'h0;
         end else if (viol && mode == dli_pkg::LM_HDB3) begin
            st_d.sr = 4'h0;
         end
      end
      st_d.rser = cfg_in[dli_pkg::RCFG_RSE] & st_q.sr[3]; // [RULE_10]
      st_d.gray = st_q.cnt ^ (st_q.cnt >> 1);
   end
   always_ff @(posedge rx_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign rser_out     = st_q.rser;
   assign cnt_gray_out = st_q.gray;
   AST_BPV_STEP: assert property (@(posedge rx_clk_in) disable iff (!rstn_in) // [RULE_15]
      (unip && v) |=> st_q.cnt == $past(st_q.cnt) + 16'h0001)
      else $error("violation counter missed a step");
   AST_RSER_PASS: assert property (@(posedge rx_clk_in) disable iff (!rstn_in) // [RULE_14]
      (unip && cfg_in[dli_pkg::RCFG_RSE])[*6] |-> rser_out == $past(d, 5))
      else $error("unipolar bit not passed to serial output");
endmodule
`default_nettype wire

// ===== dli_line_pins.sv
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dli_line_pins #(
   parameter logic [7:0] TX_HALF   = dli_pkg::TX_HALF_CYC,
   parameter logic [7:0] CLOCK_RATE_ADAPTER_HALF = dli_pkg::CLOCK_RATE_ADAPTER_HALF_CYC
) (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        tx_bit_in,
   output logic             tx_bit_take_out,
   output logic             tx_pos_rail_out,
   output logic             tx_neg_rail_out,
   output logic             tx_line_clock_out,
   output logic             tx_unipolar_data_out,
   output logic             tx_analog_pos_out,
   output logic             tx_analog_neg_out,
   input  wire logic        rx_line_clock_in,
   input  wire logic        rx_pos_rail_in,
   input  wire logic        rx_neg_rail_in,
   input  wire logic        rx_analog_pos_in,
   input  wire logic        rx_analog_neg_in,
   input  wire logic        rx_unipolar_data_in,
   input  wire logic        rx_code_violation_in,
   output logic             receive_serial_out,
   input  wire logic        reference_clock_b_in,
   output logic             reference_clock_b_out,
   output logic             reference_clock_b_oe_out,
   input  wire logic        reference_clock_c_in,
   output logic             reference_clock_c_out,
   output logic             reference_clock_c_oe_out
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [dli_pkg::CTRL_W-1:0] ctrl;
      logic [dli_pkg::INV_W-1:0]  inv;
      logic [dli_pkg::CLOCK_RATE_ADAPTER_W-1:0] clock_rate_adapter;
      logic [31:0]                prdata;
      logic                       pready;
      logic                       pslverr;
      logic [7:0]                 div;
      logic                       lclk;
      logic                       upd;
      logic [7:0]                 sr;
      logic [1:0]                 sym;
      logic                       ubit;
      logic                       last_pos;
      logic                       odd;
      logic [2:0]                 zeros;
      logic                       take;
      logic                       tpos;
      logic                       tneg;
      logic                       tclk;
      logic                       tuni;
      logic                       apos;
      logic                       aneg;
      logic [7:0]                 cdiv;
      logic                       cclk;
      logic                       bo;
      logic                       boe;
      logic                       co;
      logic                       coe;
   } dli_st_t;
   dli_st_t st_d;
   dli_st_t st_q;

   logic [1:0]                  mode;
   logic                        bip;
   logic [dli_pkg::RCFG_W-1:0]  rcfg;
   logic [dli_pkg::RCFG_W-1:0]  rcfg_rx;
   logic                        rx_clk;
   logic [dli_pkg::BPV_W-1:0]   gray_rx;
   logic [dli_pkg::BPV_W-1:0]   gray_sys;
   logic [dli_pkg::BPV_W-1:0]   bpv;
   logic [1:0]                  refin;

   assign mode = st_q.ctrl[dli_pkg::CTRL_LM +: 2];
   assign bip  = (mode != dli_pkg::LM_UNIP);

   function automatic logic [dli_pkg::BPV_W-1:0] gray2bin(input logic [dli_pkg::BPV_W-1:0] g);
      logic [dli_pkg::BPV_W-1:0] b;
      b = '0;
      b[dli_pkg::BPV_W-1] = g[dli_pkg::BPV_W-1];
      for (int i = dli_pkg::BPV_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // ----------------------------------------
   // receive side, on the line clock
   // ----------------------------------------
   // clock inversion by xor: change it only while the link is idle
   assign rx_clk = rx_line_clock_in ^ st_q.inv[dli_pkg::INV_RCLK]; // [RULE_09] [RULE_16]
   assign rcfg = {st_q.inv[dli_pkg::INV_RLCV],
                  st_q.inv[dli_pkg::INV_RDAT],
                  st_q.inv[dli_pkg::INV_RNEG],
                  st_q.inv[dli_pkg::INV_RPOS],
                  st_q.ctrl[dli_pkg::CTRL_RSE],
                  st_q.ctrl[dli_pkg::CTRL_ANA],
                  mode};

   dli_sync #(
      .W(dli_pkg::RCFG_W)
   ) u_cfg_sync (
      .clk_in  (rx_clk),
      .rstn_in (rstn_in),
      .d_in    (rcfg),
      .q_out   (rcfg_rx)
   );

   dli_rx_path u_rx (
      .rx_clk_in    (rx_clk),
      .rstn_in      (rstn_in),
      .cfg_in       (rcfg_rx),
      .pos_in       (rx_pos_rail_in),
      .neg_in       (rx_neg_rail_in),
      .apos_in      (rx_analog_pos_in),
      .aneg_in      (rx_analog_neg_in),
      .dat_in       (rx_unipolar_data_in),
      .lcv_in       (rx_code_violation_in),
      .rser_out     (receive_serial_out),
      .cnt_gray_out (gray_rx)
   );

   // gray count crosses safely: one bit moves per step
   dli_sync #(
      .W(dli_pkg::BPV_W)
   ) u_cnt_sync (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .d_in    (gray_rx),
      .q_out   (gray_sys)
   );
   assign bpv = gray2bin(gray_sys);

   dli_sync #(
      .W(2)
   ) u_ref_sync (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .d_in    ({reference_clock_c_in, reference_clock_b_in}),
      .q_out   (refin)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_d         = st_q;
      st_d.pready  = 1'b0;
      st_d.pslverr = 1'b0;
      st_d.prdata  = 32'h0000_0000;
      st_d.upd     = 1'b0;
      st_d.take    = 1'b0;
      // apb: answer in the first access cycle
      if (psel_in && !penable_in) begin
         st_d.pready = 1'b1;
         unique case (paddr_in)
            dli_pkg::ADDR_CTRL: st_d.prdata[dli_pkg::CTRL_W-1:0] = st_q.ctrl;
            dli_pkg::ADDR_INV:  st_d.prdata[dli_pkg::INV_W-1:0]  = st_q.inv;
            dli_pkg::ADDR_CLOCK_RATE_ADAPTER: st_d.prdata[4:0] = {refin, st_q.clock_rate_adapter};
            dli_pkg::ADDR_BPV:  st_d.prdata[dli_pkg::BPV_W-1:0]  = bpv;
            default:            st_d.pslverr = 1'b1;
         endcase
         if (pwrite_in) begin
            st_d.prdata = 32'h0000_0000;
         end
      end
      if (psel_in && penable_in && st_q.pready && pwrite_in) begin
         unique case (paddr_in)
            dli_pkg::ADDR_CTRL: st_d.ctrl = pwdata_in[dli_pkg::CTRL_W-1:0];
            dli_pkg::ADDR_INV:  st_d.inv  = pwdata_in[dli_pkg::INV_W-1:0];
            dli_pkg::ADDR_CLOCK_RATE_ADAPTER: st_d.clock_rate_adapter = pwdata_in[dli_pkg::CLOCK_RATE_ADAPTER_W-1:0];
            default:            st_d.ctrl = st_q.ctrl;
         endcase
      end

      // transmit line clock divider; upd marks the cycle in which lclk rises
      if (st_q.div == TX_HALF - 8'h01) begin
         st_d.div  = 8'h00;
         st_d.lclk = ~st_q.lclk;
         st_d.upd  = ~st_q.lclk;
      end else begin
         st_d.div = st_q.div + 8'h01;
      end

      // encoder: four-symbol delay so a zero run can be rewritten in place
      if (st_q.upd) begin
         st_d.take = 1'b1;
         st_d.ubit = tx_bit_in;
         st_d.sym  = st_q.sr[7:6];
         st_d.sr   = {st_q.sr[5:0], dli_pkg::SYM_SP};
         if (tx_bit_in) begin
            st_d.sr[1:0]  = st_q.last_pos ? dli_pkg::SYM_NEG : dli_pkg::SYM_POS; // [RULE_17]
            st_d.last_pos = ~st_q.last_pos;
            st_d.odd      = ~st_q.odd;
            st_d.zeros    = 3'h0;
         end else if (mode == dli_pkg::LM_AMI || mode == dli_pkg::LM_UNIP) begin
            st_d.zeros = 3'h0;
         end else if (st_q.zeros + 3'h1 ==
                      ((mode == dli_pkg::LM_HDB3) ? dli_pkg::ZRUN_HDB3 : dli_pkg::ZRUN_B3ZS)) begin
            if (st_q.odd) begin
               st_d.sr[1:0] = st_q.last_pos ? dli_pkg::SYM_POS : dli_pkg::SYM_NEG;
            end else begin
               st_d.sr[1:0]  = st_q.last_pos ? dli_pkg::SYM_NEG : dli_pkg::SYM_POS;
               st_d.last_pos = ~st_q.last_pos;
               if (mode == dli_pkg::LM_HDB3) begin
                  st_d.sr[7:6] = st_d.sr[1:0];
               end else begin
                  st_d.sr[5:4] = st_d.sr[1:0];
               end
            end
            st_d.odd   = 1'b0;
            st_d.zeros = 3'h0;
         end else begin
            st_d.zeros = st_q.zeros + 3'h1;
         end
      end

      // pin gating and polarity; rails move one cycle after the clock edge
      st_d.tpos = st_q.ctrl[dli_pkg::CTRL_TXE] & bip &
                  (st_d.sym[0] ^ st_q.inv[dli_pkg::INV_TPOS]); // [RULE_04] [RULE_05] [RULE_07]
      st_d.tneg = st_q.ctrl[dli_pkg::CTRL_TXE] & bip &
                  (st_d.sym[1] ^ st_q.inv[dli_pkg::INV_TNEG]); // [RULE_04] [RULE_05] [RULE_07]
      st_d.tclk = st_q.ctrl[dli_pkg::CTRL_TXE] &
                  (st_d.lclk ^ st_q.inv[dli_pkg::INV_TCLK]); // [RULE_06]
      st_d.tuni = st_q.ctrl[dli_pkg::CTRL_TXE] & ~bip &
                  (st_d.ubit ^ st_q.inv[dli_pkg::INV_TDAT]); // [RULE_11] [RULE_12]
      // analog drive has no inversion
      st_d.apos = st_q.ctrl[dli_pkg::CTRL_ANA] & bip & st_d.sym[0]; // [RULE_03] [RULE_07]
      st_d.aneg = st_q.ctrl[dli_pkg::CTRL_ANA] & bip & st_d.sym[1]; // [RULE_03] [RULE_07]

      // rate adapter output clock for the reference pins
      if (st_q.cdiv == CLOCK_RATE_ADAPTER_HALF - 8'h01) begin
         st_d.cdiv = 8'h00;
         st_d.cclk = ~st_q.cclk;
      end else begin
         st_d.cdiv = st_q.cdiv + 8'h01;
      end
      st_d.boe = st_q.clock_rate_adapter[dli_pkg::CLOCK_RATE_ADAPTER_EN]; // [RULE_02]
      st_d.coe = st_q.clock_rate_adapter[dli_pkg::CLOCK_RATE_ADAPTER_EN];
      st_d.bo  = st_q.clock_rate_adapter[dli_pkg::CLOCK_RATE_ADAPTER_EN] & st_q.clock_rate_adapter[dli_pkg::CLOCK_RATE_ADAPTER_BS] & st_d.cclk; // [RULE_02]
      st_d.co  = st_q.clock_rate_adapter[dli_pkg::CLOCK_RATE_ADAPTER_EN] & st_q.clock_rate_adapter[dli_pkg::CLOCK_RATE_ADAPTER_CS] & st_d.cclk;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_q      <= '0;
         st_q.ctrl <= dli_pkg::CTRL_RST;
         st_q.inv  <= dli_pkg::INV_RST;
         st_q.clock_rate_adapter <= dli_pkg::CLOCK_RATE_ADAPTER_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata_out               = st_q.prdata;
   assign pready_out               = st_q.pready;
   assign pslverr_out              = st_q.pslverr;
   assign tx_bit_take_out          = st_q.take;
   assign tx_pos_rail_out          = st_q.tpos;
   assign tx_neg_rail_out          = st_q.tneg;
   assign tx_line_clock_out        = st_q.tclk;
   assign tx_unipolar_data_out     = st_q.tuni;
   assign tx_analog_pos_out        = st_q.apos;
   assign tx_analog_neg_out        = st_q.aneg;
   assign reference_clock_b_out    = st_q.bo;
   assign reference_clock_b_oe_out = st_q.boe;
   assign reference_clock_c_out    = st_q.co;
   assign reference_clock_c_oe_out = st_q.coe;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_ANALOG_GATE: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_03]
      (tx_analog_pos_out || tx_analog_neg_out) |->
      $past(bip && st_q.ctrl[dli_pkg::CTRL_ANA]))
      else $error("analog output active outside bipolar interface mode");
   AST_RAIL_GATE: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_04]
      (tx_pos_rail_out || tx_neg_rail_out) |->
      $past(bip && st_q.ctrl[dli_pkg::CTRL_TXE]))
      else $error("transmit rail active while not enabled");
   AST_RAIL_EDGE: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_05]
      ($changed(tx_pos_rail_out) && $past(st_q.ctrl) == $past(st_q.ctrl, 2) &&
       $past(st_q.inv) == $past(st_q.inv, 2)) |-> $past(st_q.upd))
      else $error("rail changed away from the clock edge");
   AST_RAIL_EXCL: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_17]
      ($past(st_q.inv[dli_pkg::INV_TPOS] | st_q.inv[dli_pkg::INV_TNEG]) == 1'b0) |->
      !(tx_pos_rail_out && tx_neg_rail_out))
      else $error("both rails marked at once");
   AST_UNI_GATE: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_11]
      tx_unipolar_data_out |-> $past(!bip && st_q.ctrl[dli_pkg::CTRL_TXE]))
      else $error("unipolar data driven outside unipolar mode");
   AST_UNI_LAUNCH: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_12]
      (st_q.upd && st_q.ctrl[dli_pkg::CTRL_TXE] && !bip && $stable(st_q.ctrl) && $stable(st_q.inv)) |=>
      tx_unipolar_data_out == $past(tx_bit_in ^ st_q.inv[dli_pkg::INV_TDAT]))
      else $error("unipolar data not launched from the taken bit");
   AST_CLOCK_RATE_ADAPTER_LOW: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_02]
      $past(st_q.clock_rate_adapter[dli_pkg::CLOCK_RATE_ADAPTER_EN] && !st_q.clock_rate_adapter[dli_pkg::CLOCK_RATE_ADAPTER_BS]) |->
      (reference_clock_b_oe_out && !reference_clock_b_out))
      else $error("unselected reference pin not held low");
   AST_TX_CLOCK_DIV: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE_06]
      $rose(st_q.lclk) |-> st_q.upd)
      else $error("launch cycle missing after clock rise");
endmodule
`default_nettype wire

// ===== dli_line_pins_dummy_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== dli_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module dli_far_end (
   input  wire logic       run_in,
   input  wire logic       dat_in,
   input  wire logic [3:0] lcv_len_in,
   input  wire logic       lcv_go_in,
   output logic            clk_out,
   output logic            dat_out,
   output logic            lcv_out,
   output logic            pos_out,
   output logic            neg_out
);
   logic [3:0] left;
   logic       seen;
   logic       ph;
   initial begin
      {clk_out, dat_out, lcv_out, pos_out, neg_out, seen, ph} = 7'h00;
      left = 4'h0;
   end
   // clock stands low between frames
   always begin
      #15;
      clk_out = run_in ? ~clk_out : 1'b0;
   end
   // launch on falling edge, so the rising edge sees settled data
   always @(negedge clk_out) begin
      dat_out <= dat_in;
      lcv_out <= (left != 4'h0);
      left    <= (lcv_go_in & ~seen) ? lcv_len_in : left - {3'h0, left != 4'h0};
      seen    <= lcv_go_in;
      ph      <= ph ^ dat_in;
      pos_out <= dat_in & ~ph;
      neg_out <= dat_in & ph;
   end
endmodule
`default_nettype wire

// ===== dli_line_pins_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dli_line_pins_bench;
   typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic e;} dli_row_t;
   logic        clk_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic        ps = 1'b0, pe = 1'b0, pw = 1'b0, tb = 1'b0, run = 1'b1, dat = 1'b0, go = 1'b0;
   logic        rb = 1'b0, rc = 1'b0, rdy, err, tk, tp, tn, tc, tu, ap, an, rs, rclk, fd, fl, fp, fn;
   logic        bo, boe, co, coe, e;
   logic [7:0]  pa = 8'h00;
   logic [31:0] wd = 32'h0, prd, rd;
   int          mismatches = 0, n_checks = 0, np, nn, na, nb, nt, nc;
   dli_row_t    rows [11] = '{'{0, 8'h00, 32'h0, 0}, '{0, 8'h04, 32'h0, 0}, '{0, 8'h08, 32'h0, 0},
      '{0, 8'h0C, 32'h0, 0}, '{1, 8'h00, 32'hFFFFFFFF, 0}, '{0, 8'h00, 32'h1F, 0},
      '{1, 8'h04, 32'hFFFFFFFF, 0}, '{0, 8'h04, 32'h1FF, 0}, '{1, 8'h0C, 32'hFFFF, 0},
      '{0, 8'h0C, 32'h0, 0}, '{0, 8'h10, 32'h0, 1}};
   // system clock stands in for the DS3 rate source on reference_clock_a
   always #2.5 clk_in = ~clk_in;
   dli_line_pins dli_line_pins_inst (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(ps), .penable_in(pe),
      .pwrite_in(pw), .paddr_in(pa), .pwdata_in(wd), .prdata_out(prd), .pready_out(rdy), .pslverr_out(err),
      .tx_bit_in(tb), .tx_bit_take_out(tk), .tx_pos_rail_out(tp), .tx_neg_rail_out(tn),
      .tx_line_clock_out(tc), .tx_unipolar_data_out(tu), .tx_analog_pos_out(ap), .tx_analog_neg_out(an),
      .rx_line_clock_in(rclk), .rx_pos_rail_in(fp), .rx_neg_rail_in(fn), .rx_analog_pos_in(fp),
      .rx_analog_neg_in(fn), .rx_unipolar_data_in(fd), .rx_code_violation_in(fl),
      .receive_serial_out(rs), .reference_clock_b_in(rb), .reference_clock_b_out(bo),
      .reference_clock_b_oe_out(boe), .reference_clock_c_in(rc), .reference_clock_c_out(co),
      .reference_clock_c_oe_out(coe));
   dli_far_end dli_far_end_inst (.run_in(run), .dat_in(dat), .lcv_len_in(4'h6), .lcv_go_in(go),
      .clk_out(rclk), .dat_out(fd), .lcv_out(fl), .pos_out(fp), .neg_out(fn));
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         mismatches++;
         $display("unexpected %s expected %0h seen %0h", nm, x, g);
      end
   endtask
   // one transfer; answer taken at the rising edge that samples pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_in);
      {ps, pe, pw, pa, wd} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk_in);
      pe <= 1'b1;
      i = 0;
      do begin
         @(posedge clk_in);
         i++;
      end while (rdy !== 1'b1 && i < 20);
      if (rdy !== 1'b1) begin
         mismatches++;
         print_verdict();
      end
      {rd, e} = {prd, err};
      {ps, pe} <= 2'b00;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   initial begin
      repeat (20) @(posedge clk_in);
      rstn_in <= 1'b1;
      foreach (rows[k]) begin
         apb(rows[k].wr, rows[k].a, rows[k].d);
         chk("slverr", {31'h0, rows[k].e}, {31'h0, e});
         if (!rows[k].wr) chk("read data", rows[k].d, rd);
      end
      // every line mode, all marks, pins and interface on
      apb(1, 8'h04, 32'h0);
      tb <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         apb(1, 8'h00, 32'h0C | m);
         settle(30);
         {np, nn, na, nb, nt, nc} = 192'h0;
         repeat (64) begin
            @(negedge clk_in);
            nt += int'(tk === 1'b1);
            nc += int'(tc === 1'b1);
            np += int'(tp === 1'b1);
            nn += int'(tn === 1'b1);
            na += int'(ap === 1'b1 || an === 1'b1);
            nb += int'(tp === 1'b1 && tn === 1'b1);
         end
         chk("both rails high", 0, nb);
         chk("marks on both rails", m < 3, np > 0 && nn > 0);
         chk("analog pulses", m < 3, na > 0);
         chk("unipolar data", m == 3, tu);
         chk("take pulses", 16, nt);
         chk("line clock high", 32, nc);
      end
      // spaces with rail inversion: analog stays uninverted
      apb(1, 8'h00, 32'h0E);
      tb <= 1'b0;
      apb(1, 8'h04, 32'h06);
      settle(40);
      chk("inverted rails", 3, {tp, tn});
      chk("analog not inverted", 0, {ap, an});
      apb(1, 8'h00, 32'h0B);
      tb <= 1'b1;
      apb(1, 8'h04, 32'h08);
      settle(30);
      chk("inverted unipolar", 0, tu);
      apb(1, 8'h00, 32'h03);
      settle(10);
      chk("unipolar gated", 0, tu);
      // receive: rails without interface, analog with it, then unipolar
      apb(1, 8'h04, 32'h0);
      dat <= 1'b1;
      for (int m = 0; m < 3; m++) begin
         apb(1, 8'h00, m == 0 ? 32'h12 : m == 1 ? 32'h16 : 32'h13);
         settle(120);
         chk("receive serial", 1, rs);
      end
      apb(1, 8'h04, 32'h80);
      settle(120);
      chk("inverted rx data", 0, rs);
      apb(0, 8'h0C, 32'h0);
      np = int'(rd);
      go <= 1'b1;
      settle(400);
      apb(0, 8'h0C, 32'h0);
      chk("violation count", 6, rd - np);
      run <= 1'b0;
      // adapter on, neither pin selected: driven low
      rb <= 1'b1;
      apb(1, 8'h08, 32'h1);
      settle(10);
      chk("ref pins", 4'h5, {bo, boe, co, coe});
      apb(0, 8'h08, 32'h0);
      chk("adapter reg", 32'h09, rd);
      apb(1, 8'h08, 32'h3);
      settle(10);
      na = int'(bo);
      settle(2);
      chk("selected ref clock", 1, na != int'(bo));
      print_verdict();
   end
endmodule
`default_nettype wire
